// ==== rtl/tmw_defs.vh ====
// Constants for the 16-bit timer waveform generator
`ifndef TMW_DEFS_VH
`define TMW_DEFS_VH
// ============================================================
// APB register offsets (byte addresses)
`define TMW_OFS_CTRL 12'h000
`define TMW_OFS_COUNT 12'h004
`define TMW_OFS_CMPA 12'h008
`define TMW_OFS_CMPB 12'h00C
`define TMW_OFS_CAPT 12'h010
`define TMW_OFS_FLAGS 12'h014
// ============================================================
// Control field positions
`define TMW_WGM_LSB 0
`define TMW_WGM_MSB 3
`define TMW_COMA_LSB 4
`define TMW_COMA_MSB 5
`define TMW_COMB_LSB 6
`define TMW_COMB_MSB 7
`define TMW_TICK_BIT 8
`define TMW_DIRA_BIT 9
`define TMW_DIRB_BIT 10
// Flag bit positions
`define TMW_FLG_OVF 0
`define TMW_FLG_CMPA 1
`define TMW_FLG_CMPB 2
`define TMW_FLG_CAPT 3
// ============================================================
// Mode codes and fixed values
`define TMW_M_PC8 4'h1
`define TMW_M_PC9 4'h2
`define TMW_M_PC10 4'h3
`define TMW_M_CTC_A 4'h4
`define TMW_M_FP8 4'h5
`define TMW_M_FP9 4'h6
`define TMW_M_FP10 4'h7
`define TMW_M_PC_CAP 4'hA
`define TMW_M_PC_A 4'hB
`define TMW_M_CTC_CAP 4'hC
`define TMW_M_FP_CAP 4'hE
`define TMW_M_FP_A 4'hF
`define TMW_TOP8 16'h00FF
`define TMW_TOP9 16'h01FF
`define TMW_TOP10 16'h03FF
`define TMW_MAX 16'hFFFF
`define TMW_BOTTOM 16'h0000
`define TMW_RST_CTRL 11'h000
`define TMW_RST_16 16'h0000
`endif

// ==== rtl/tmw_mode_decode.v ====
// Decodes the waveform mode into mode class and TOP source
`timescale 1ns/100ps
`include "tmw_defs.vh"
module tmw_mode_decode (
	wgm,
	cap_val,
	cmpa_act,
	is_ctc,
	is_fast,
	is_pc,
	top_val,
	top_cap,
	top_cmpa,
	fix_mask
);
	input wire [3:0] wgm;
	input wire [15:0] cap_val;
	input wire [15:0] cmpa_act;
	output reg is_ctc;
	output reg is_fast;
	output reg is_pc;
	output reg [15:0] top_val;
	output reg top_cap;
	output reg top_cmpa;
	output reg [15:0] fix_mask;

	// ============================================================
	// Mode decode
	always @* begin
		is_ctc = 1'b0;
		is_fast = 1'b0;
		is_pc = 1'b0;
		top_val = `TMW_MAX;
		top_cap = 1'b0;
		top_cmpa = 1'b0;
		fix_mask = `TMW_MAX;
		case (wgm)
			`TMW_M_CTC_A: begin
				is_ctc = 1'b1;
				top_val = cmpa_act;
				top_cmpa = 1'b1;
			end
			`TMW_M_CTC_CAP: begin
				is_ctc = 1'b1;
				top_val = cap_val;
				top_cap = 1'b1;
			end
			`TMW_M_FP8, `TMW_M_PC8: begin
				is_fast = (wgm == `TMW_M_FP8);
				is_pc = (wgm == `TMW_M_PC8);
				top_val = `TMW_TOP8;
				fix_mask = `TMW_TOP8;
			end
			`TMW_M_FP9, `TMW_M_PC9: begin
				is_fast = (wgm == `TMW_M_FP9);
				is_pc = (wgm == `TMW_M_PC9);
				top_val = `TMW_TOP9;
				fix_mask = `TMW_TOP9;
			end
			`TMW_M_FP10, `TMW_M_PC10: begin
				is_fast = (wgm == `TMW_M_FP10);
				is_pc = (wgm == `TMW_M_PC10);
				top_val = `TMW_TOP10;
				fix_mask = `TMW_TOP10;
			end
			`TMW_M_FP_CAP, `TMW_M_PC_CAP: begin
				is_fast = (wgm == `TMW_M_FP_CAP);
				is_pc = (wgm == `TMW_M_PC_CAP);
				top_val = cap_val;
				top_cap = 1'b1;
			end
			`TMW_M_FP_A, `TMW_M_PC_A: begin
				is_fast = (wgm == `TMW_M_FP_A);
				is_pc = (wgm == `TMW_M_PC_A);
				top_val = cmpa_act;
				top_cmpa = 1'b1;
			end
			default: begin
				// Other modes: free running up counter
				is_ctc = 1'b0;
			end
		endcase
	end
endmodule // tmw_mode_decode

// ==== rtl/tmw_timer16.v ====
// 16-bit timer waveform generator with APB registers
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "tmw_defs.vh"
module tmw_timer16 (
	core_clk,
	sys_rst,
	timer_tick_enable,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	pin_out_a,
	pin_oe_a,
	pin_out_b,
	pin_oe_b
);
	input wire core_clk;
	input wire sys_rst;
	input wire timer_tick_enable;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [11:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output reg pready;
	output reg pslverr;
	output wire pin_out_a;
	output wire pin_oe_a;
	output wire pin_out_b;
	output wire pin_oe_b;

	// ============================================================
	// State
	reg [10:0] ctrl_r; // Mode, output modes, directions
	reg [15:0] count_r; // counter_value
	reg count_up_r; // Direction in phase correct mode
	reg [15:0] cmpa_act_r; // Active compare_a_value
	reg [15:0] cmpa_buf_r; // Buffered compare_a_value
	reg [15:0] cmpb_act_r; // Active compare B value
	reg [15:0] cmpb_buf_r; // Buffered compare B value
	reg [15:0] cap_r; // capture_value
	reg [3:0] flags_r; // Sticky flags
	reg blk_r; // Match block after counter write

	wire [3:0] waveform_mode_select = ctrl_r[`TMW_WGM_MSB:`TMW_WGM_LSB];
	wire [1:0] compare_a_output_mode = ctrl_r[`TMW_COMA_MSB:`TMW_COMA_LSB];
	wire [1:0] com_b = ctrl_r[`TMW_COMB_MSB:`TMW_COMB_LSB];
	wire tick = timer_tick_enable | ctrl_r[`TMW_TICK_BIT];

	wire is_ctc;
	wire is_fast;
	wire is_pc;
	wire [15:0] top_val;
	wire top_cap;
	wire top_cmpa;
	wire [15:0] fix_mask;

	// ============================================================
	// Mode decode
	tmw_mode_decode u_dec (
		.wgm(waveform_mode_select),
		.cap_val(cap_r),
		.cmpa_act(cmpa_act_r),
		.is_ctc(is_ctc),
		.is_fast(is_fast),
		.is_pc(is_pc),
		.top_val(top_val),
		.top_cap(top_cap),
		.top_cmpa(top_cmpa),
		.fix_mask(fix_mask)
	);

	// ============================================================
	// Counter events
	wire is_pwm = is_fast | is_pc;
	wire at_top = (count_r == top_val) & ~blk_r;
	wire at_max = (count_r == `TMW_MAX);
	wire at_bot = (count_r == `TMW_BOTTOM);
	wire hit_a = (count_r == cmpa_act_r) & ~blk_r;
	wire hit_b = (count_r == cmpb_act_r) & ~blk_r;
	// Direction the counter is going in this tick
	wire pc_up = at_top ? 1'b0 : (at_bot ? 1'b1 : count_up_r);
	wire fast_bottom = is_fast & at_top; // Next tick is bottom

	// Bus strobes
	wire acc = psel & penable;
	wire wr = acc & pwrite;

	// Write decoding used by several registers
	function sel;
		input [11:0] a;
		input [11:0] ofs;
		begin
			sel = (a == ofs);
		end
	endfunction

	wire wr_ctrl = wr & sel(paddr, `TMW_OFS_CTRL);
	wire wr_cnt = wr & sel(paddr, `TMW_OFS_COUNT);
	wire wr_cmpa = wr & sel(paddr, `TMW_OFS_CMPA);
	wire wr_cmpb = wr & sel(paddr, `TMW_OFS_CMPB);
	wire wr_cap = wr & sel(paddr, `TMW_OFS_CAPT);
	wire wr_flg = wr & sel(paddr, `TMW_OFS_FLAGS);
	// Compare write value, upper bits cleared for fixed TOP
	wire [15:0] cmp_wval = pwdata[15:0] & fix_mask;
	// Active compare values are loaded from the buffers at TOP in PWM modes
	wire load_top = tick & at_top & is_pwm;

	// ============================================================
	// Counter and direction
	always @(posedge core_clk) begin
		if (sys_rst) begin
			count_r <= `TMW_RST_16;
			count_up_r <= 1'b1;
			blk_r <= 1'b0;
		end else if (wr_cnt) begin
			count_r <= pwdata[15:0];
			blk_r <= 1'b1;
		end else if (tick) begin
			blk_r <= 1'b0;
			if (is_pc) begin
				count_up_r <= pc_up;
				if (pc_up)
					count_r <= count_r + 16'h0001;
				else
					count_r <= count_r - 16'h0001;
			end else if ((is_ctc | is_fast) & at_top) begin
				count_r <= `TMW_BOTTOM;
			end else begin
				count_r <= count_r + 16'h0001;
				count_up_r <= 1'b1;
			end
		end
	end

	// ============================================================
	// Compare and capture registers
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cmpa_act_r <= `TMW_RST_16;
			cmpa_buf_r <= `TMW_RST_16;
			cmpb_act_r <= `TMW_RST_16;
			cmpb_buf_r <= `TMW_RST_16;
			cap_r <= `TMW_RST_16;
		end else begin
			if (wr_cmpa)
				cmpa_buf_r <= cmp_wval;
			if (wr_cmpb)
				cmpb_buf_r <= cmp_wval;
			if (wr_cap)
				cap_r <= pwdata[15:0];
			// Unbuffered outside PWM, loaded at TOP inside
			if (!is_pwm && wr_cmpa)
				cmpa_act_r <= cmp_wval;
			else if (load_top)
				cmpa_act_r <= cmpa_buf_r;
			if (!is_pwm && wr_cmpb)
				cmpb_act_r <= cmp_wval;
			else if (load_top)
				cmpb_act_r <= cmpb_buf_r;
		end
	end

	// ============================================================
	// Flags: a hardware set wins over a software clear
	reg [3:0] set_v; // Flags set this cycle
	always @* begin
		set_v = 4'h0;
		if (tick) begin
			if (is_ctc) begin
				set_v[`TMW_FLG_OVF] = at_max;
				set_v[`TMW_FLG_CMPA] = at_top & top_cmpa;
				set_v[`TMW_FLG_CAPT] = at_top & top_cap;
			end else if (is_fast) begin
				set_v[`TMW_FLG_OVF] = at_top;
				set_v[`TMW_FLG_CAPT] = at_top & top_cap;
			end else if (is_pc) begin
				set_v[`TMW_FLG_OVF] = at_bot & ~count_up_r;
				set_v[`TMW_FLG_CAPT] = at_top & top_cap;
			end else begin
				set_v[`TMW_FLG_OVF] = at_max;
			end
			if (is_pwm) begin
				// Compare A also covers TOP when it is the TOP source
				set_v[`TMW_FLG_CMPA] = hit_a;
				set_v[`TMW_FLG_CMPB] = hit_b;
			end else begin
				set_v[`TMW_FLG_CMPA] = set_v[`TMW_FLG_CMPA] | hit_a;
				set_v[`TMW_FLG_CMPB] = hit_b;
			end
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			flags_r <= 4'h0;
		else if (wr_flg)
			flags_r <= (flags_r & ~pwdata[3:0]) | set_v;
		else
			flags_r <= flags_r | set_v;
	end

	// ============================================================
	// Control register
	always @(posedge core_clk) begin
		if (sys_rst)
			ctrl_r <= `TMW_RST_CTRL;
		else if (wr_ctrl)
			ctrl_r <= pwdata[10:0];
	end

	// ============================================================
	// Wave channels
	tmw_wave_ch u_cha (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.hit(hit_a),
		.at_bottom(fast_bottom),
		.count_up(pc_up),
		.com(compare_a_output_mode),
		.is_ctc(is_ctc),
		.is_fast(is_fast),
		.is_pc(is_pc),
		.pin_direction(ctrl_r[`TMW_DIRA_BIT]),
		.wave_out(),
		.pin_out(pin_out_a),
		.pin_oe(pin_oe_a)
	);

	tmw_wave_ch u_chb (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.hit(hit_b),
		.at_bottom(fast_bottom),
		.count_up(pc_up),
		.com(com_b),
		.is_ctc(1'b0),
		.is_fast(is_fast),
		.is_pc(is_pc),
		.pin_direction(ctrl_r[`TMW_DIRB_BIT]),
		.wave_out(),
		.pin_out(pin_out_b),
		.pin_oe(pin_oe_b)
	);

	// ============================================================
	// APB read path and handshake: one wait-free access phase
	always @(posedge core_clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel & ~penable) begin
				if (sel(paddr, `TMW_OFS_CTRL))
					prdata <= {21'h00000, ctrl_r};
				else if (sel(paddr, `TMW_OFS_COUNT))
					prdata <= {16'h0000, count_r};
				else if (sel(paddr, `TMW_OFS_CMPA))
					prdata <= {16'h0000, cmpa_buf_r};
				else if (sel(paddr, `TMW_OFS_CMPB))
					prdata <= {16'h0000, cmpb_buf_r};
				else if (sel(paddr, `TMW_OFS_CAPT))
					prdata <= {16'h0000, cap_r};
				else if (sel(paddr, `TMW_OFS_FLAGS))
					prdata <= {28'h0000000, flags_r};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule // tmw_timer16

// ==== rtl/tmw_wave_ch.v ====
// One compare channel: wave output state and pin drive
`timescale 1ns/100ps
`include "tmw_defs.vh"
module tmw_wave_ch (
	core_clk,
	sys_rst,
	tick,
	hit,
	at_bottom,
	count_up,
	com,
	is_ctc,
	is_fast,
	is_pc,
	pin_direction,
	wave_out,
	pin_out,
	pin_oe
);
	input wire core_clk;
	input wire sys_rst;
	input wire tick;
	input wire hit;
	input wire at_bottom;
	input wire count_up;
	input wire [1:0] com;
	input wire is_ctc;
	input wire is_fast;
	input wire is_pc;
	input wire pin_direction;
	output reg wave_out;
	output reg pin_out;
	output reg pin_oe;

	reg wave_nxt; // Next internal output state

	// ============================================================
	// Output action per mode
	always @* begin
		wave_nxt = wave_out;
		if (tick && com != 2'b00) begin
			if (com == 2'b01 && (is_ctc || is_fast)) begin
				if (hit)
					wave_nxt = ~wave_out;
			end else if (is_fast && com[1]) begin
				if (hit)
					wave_nxt = com[0];
				else if (at_bottom)
					wave_nxt = ~com[0];
			end else if (is_pc && com[1]) begin
				if (hit)
					wave_nxt = count_up ? com[0] : ~com[0];
			end
		end
	end

	// ============================================================
	// Registered state and pin drive
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wave_out <= 1'b0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			wave_out <= wave_nxt;
			pin_out <= wave_nxt;
			// Pin driven only when the port is an output
			pin_oe <= pin_direction & (com != 2'b00);
		end
	end
endmodule // tmw_wave_ch

// ==== verif/tmw_pin_load.sv ====
// External load on one wave pin: resolves the pad level
`timescale 1ns/100ps
module tmw_pin_load (
	input wire core_clk,
	input wire pin_out,
	input wire pin_oe,
	output wire pad
);
	// Undriven pad wanders every cycle, never holds a stale level
	reg float_r = 1'b0;
	always @(posedge core_clk) begin
		float_r <= ~float_r;
	end
	// Pad shows the wave only while driven
	assign pad = pin_oe ? pin_out : float_r;
endmodule // tmw_pin_load

// ==== verif/tmw_timer16_props.sv ====
// Port-level checker for the timer waveform block
`timescale 1ns/100ps
module tmw_timer16_props (
	input wire core_clk,
	input wire sys_rst,
	input wire timer_tick_enable,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire pin_out_a,
	input wire pin_oe_a,
	input wire pin_out_b,
	input wire pin_oe_b
);
	// ============================================================
	// Shadow of the control word, taken from completed writes
	reg [10:0] ctl_r;
	wire tck;
	// Effective tick: pin or forced by control bit 8
	assign tck = timer_tick_enable | ctl_r[8];
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ctl_r <= 11'h000;
		end else if (psel && penable && pwrite && pready && paddr == 12'h000) begin
			ctl_r <= pwdata[10:0];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ============================================================
	// Bus answer timing and refusal
	a_setup_ready: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (pready |-> pslverr == (paddr > 12'h014))
		else $error("error flag wrong for address");
	a_err_reads_zero: assert property (pready && pslverr && !pwrite |->
		prdata == 32'h00000000) else $error("refused read not zero");
	// ============================================================
	// Wave state moves only on a tick
	a_wave_a_gated: assert property (
		!tck |=> $stable(pin_out_a)) else $error("wave A moved without tick");
	a_wave_b_gated: assert property (
		!tck |=> $stable(pin_out_b)) else $error("wave B moved without tick");
	// Pin drive follows direction and output mode
	a_oe_a_dir: assert property (
		$stable(ctl_r) |-> pin_oe_a == (ctl_r[9] && ctl_r[5:4] != 2'h0))
		else $error("pin A enable wrong");
	a_oe_b_dir: assert property (
		$stable(ctl_r) |-> pin_oe_b == (ctl_r[10] && ctl_r[7:6] != 2'h0))
		else $error("pin B enable wrong");
	// Main scenarios reached
	c_unmapped: cover property (pready && pslverr);
	c_drive_a: cover property (pin_oe_a && $rose(pin_out_a));
	c_stall: cover property (!tck ##1 !tck);
endmodule // tmw_timer16_props
bind tmw_timer16 tmw_timer16_props chk_u (.core_clk, .sys_rst,
	.timer_tick_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .pin_out_a, .pin_oe_a, .pin_out_b, .pin_oe_b);

// ==== verif/tmw_timer16_tb.sv ====
// Self-checking bench for the timer waveform block
`timescale 1ns/100ps
module tmw_timer16_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic timer_tick_enable = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata;
	wire pready, pslverr, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, pad_a;
	int num_errors = 0;
	int n_checks = 0;
	int hi, lo;
	logic [31:0] rv;
	logic er;
	// Rows: ctrl, cmpa, capt, high, low, flags, flag mask
	int rows[11][7] = '{
		'{12'h214, 4, 0, 5, 5, 4'h2, 4'hB},
		'{12'h21C, 0, 4, 5, 5, 4'h8, 4'h9},
		'{12'h22E, 3, 9, 4, 6, 4'hF, 4'hF},
		'{12'h23E, 3, 9, 6, 4, 4'hF, 4'hF},
		'{12'h22E, 0, 9, 1, 9, 4'hF, 4'hF},
		'{12'h21F, 5, 0, 6, 6, 4'h7, 4'hF},
		'{12'h225, 16, 0, 17, 239, 4'h7, 4'hF},
		'{12'h22A, 3, 9, 6, 12, 4'hF, 4'hF},
		'{12'h23A, 3, 9, 12, 6, 4'hF, 4'hF},
		'{12'h221, 16, 0, 32, 478, 4'h7, 4'hF},
		'{12'h02E, 3, 9, 4, 6, 4'hF, 4'hF}
	};
	// Device and pin load
	tmw_timer16 dut_u (.core_clk, .sys_rst, .timer_tick_enable, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pin_out_a, .pin_oe_a, .pin_out_b, .pin_oe_b);
	tmw_pin_load ld_u (.core_clk, .pin_out(pin_out_a), .pin_oe(pin_oe_a),
		.pad(pad_a));
	// 100 ns clock
	always #50 core_clk = ~core_clk;
	// ============================================================
	// Compare and report
	task chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	// One bus transfer, entered just after a rising edge
	task apb(input bit w, input [11:0] a, input [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rv = prdata;
		er = pslverr;
		chk(n < 16, "bus hang");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rv === e, "read data");
	endtask
	// Time high and low phases of wave A from a fresh rise
	task meas;
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (pin_out_a !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		while (pin_out_a !== 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		while (pin_out_a === 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
			hi++;
		end
		while (pin_out_a === 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
			lo++;
		end
		// Hand back just after a rising edge, as the bus task expects
		@(posedge core_clk);
	endtask
	// Stop, load values in mode zero, start a mode and time it
	task run(input [31:0] c, input [31:0] a, input [31:0] p);
		@(posedge core_clk);
		timer_tick_enable <= 1'b0;
		apb(1'b1, 12'h000, 32'h00000000);
		apb(1'b1, 12'h004, 32'h00000000);
		apb(1'b1, 12'h010, p);
		apb(1'b1, 12'h008, a);
		apb(1'b1, 12'h014, 32'h0000000F);
		apb(1'b1, 12'h000, c);
		timer_tick_enable <= 1'b1;
		meas;
	endtask
	task finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk(pin_out_a === 1'b0 && pin_oe_a === 1'b0, "reset pins");
		for (int a = 0; a < 24; a += 4) rd(a[11:0], 32'h00000000);
		apb(1'b0, 12'h018, 32'h00000000);
		chk(er === 1'b1 && rv === 32'h00000000, "unmapped read");
		apb(1'b1, 12'h018, 32'h000007FF);
		rd(12'h000, 32'h00000000);
		// Fixed TOP masks compare writes
		apb(1'b1, 12'h000, 32'h00000005);
		apb(1'b1, 12'h008, 32'h00001234);
		rd(12'h008, 32'h00000034);
		apb(1'b1, 12'h000, 32'h00000007);
		apb(1'b1, 12'h008, 32'h00001234);
		rd(12'h008, 32'h00000234);
		// Waveform table
		foreach (rows[i]) begin
			run(rows[i][0], rows[i][1], rows[i][2]);
			chk(hi == rows[i][3] && lo == rows[i][4], "wave timing");
			chk(pin_oe_a === rows[i][0][9], "pin enable");
			chk(pin_oe_b === 1'b0, "pin B enable");
			chk(!pin_oe_a || pad_a === pin_out_a, "pad level");
			apb(1'b0, 12'h014, 32'h00000000);
			chk((rv & rows[i][6]) === rows[i][5], "flags");
		end
		// Output mode zero leaves the wave alone
		run(32'h0000020E, 32'h00000003, 32'h00000009);
		chk(hi == 0 && lo == 0 && pin_oe_a === 1'b0, "mode zero");
		// Counter frozen without a tick
		timer_tick_enable <= 1'b0;
		apb(1'b0, 12'h004, 32'h00000000);
		repeat (5) @(posedge core_clk);
		rd(12'h004, rv);
		// Buffered TOP change waits for TOP, so no wrap
		run(32'h0000021F, 32'h00000013, 32'h00000000);
		repeat (8) @(posedge core_clk);
		apb(1'b1, 12'h008, 32'h00000005);
		meas;
		chk(hi == 6 && lo == 6, "buffered compare");
		finish_test;
	end
	// Watchdog cuts a hang short
	initial begin
		#3000000;
		num_errors++;
		finish_test;
	end
endmodule // tmw_timer16_tb
